// file: rtl/pmsq_pkg.sv
// shared constants and types of the power sequencer
// assumes a single 25 MHz clock and a plain register port
package pmsq_pkg;

  // **************************************
  // rails and strobes
  // **************************************
  localparam int RAILS    = 10;  // 0..3 converters, 4 linear_reg
  localparam int MON      = 5;   // supervised rails 0..4
  localparam int STROBES  = 10;  // strobe slots 1..10
  localparam int LOWSW    = 5;   // low_volt_switch
  localparam int FIVESW   = 6;   // five_volt_switch
  localparam int HIGHSW   = 7;   // high_volt_switch
  localparam int BKA      = 8;   // backup_buck_a
  localparam int BKB      = 9;   // backup_buck_b

  // **************************************
  // register offsets and fields
  // **************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ENABLE  = 8'h04;  // rail_enable_reg
  localparam logic [7:0] OFS_SLOT_LO = 8'h08;  // strobe_slot rails 0..7
  localparam logic [7:0] OFS_SLOT_HI = 8'h0C;  // strobe_slot rails 8..9
  localparam logic [7:0] OFS_DELAY   = 8'h10;  // step_delay, 2 bits each
  localparam logic [7:0] OFS_GOODDLY = 8'h14;  // good_release_delay, ms
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam int CTRL_STRETCH = 0;  // delay_stretch
  localparam int CTRL_SEAL    = 1;  // backup_rail_seal
  localparam int CTRL_LONG    = 2;  // long_press_select
  localparam int CTRL_TIGHT   = 3;  // tight_supervision
  localparam int CTRL_SUSP    = 4;  // host release goes to suspend

  // **************************************
  // reset values
  // **************************************
  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [9:0]  ENABLE_RST  = 10'h000;
  localparam logic [39:0] SLOT_RST    = 40'h2100876543;
  localparam logic [17:0] DELAY_RST   = 18'h00000;
  localparam logic [7:0]  GOODDLY_RST = 8'h0A;

  // **************************************
  // timing
  // **************************************
  localparam int CLK_HZ        = 25_000_000;
  localparam int BASE_US       = 10;   // common fine tick
  localparam int BASE_CYCLES   = CLK_HZ / 1_000_000 * BASE_US;
  localparam int MS_US         = 1000;
  localparam int BASE_PER_MS   = MS_US / BASE_US;
  localparam int DLY_MIN_MS    = 2;
  localparam int STRETCH       = 10;
  localparam int DOWN_MS       = 500;
  localparam int DISCH_MIN_MS  = 150;
  localparam int AWAIT_MS      = 20000;
  localparam int PRESS_MS      = 8000;
  localparam int PRESS_LONG_MS = 15000;
  localparam int ARM_MS        = 5;
  localparam int UV_RELAX_US   = 1000;
  localparam int UV_TIGHT_US   = 50;
  localparam int OV_US         = 1000;
  localparam int UV_RELAX_TK   = UV_RELAX_US / BASE_US;
  localparam int UV_TIGHT_TK   = UV_TIGHT_US / BASE_US;
  localparam int OV_TK         = OV_US / BASE_US;

  // power states
  typedef enum logic [2:0] {
    ST_OFF, ST_AWAIT, ST_ACTIVE, ST_SUSPEND, ST_RECOVERY, ST_DOWN
  } pmsq_state_type;

endpackage

// file: rtl/pmsq_sequencer.sv
// power sequencer: wake logic, strobe sequencing, supervisor
// assumes pins are asynchronous and reset comes from input brown-out
`timescale 1ns/1ps

// What this block does
// - ten strobes, nine delays, rails enabled
// - one slot field per rail
// - first strobe immediate, then 2-5 ms steps
// - off wakes on edges, request, bias
// - suspend wakes on edges or request level
// - 20 s without request powers down
// - request moves to active; release powers down
// - slot zero rails keep their state
// - enable bits show rails, sequencer updates
// - power-down reverse from strobe ten
// - delay_stretch makes down delays tenfold
// - target state exactly 500 ms later
// - suspend keeps unsequenced rails as they were
// - off/recovery unsequenced rails 0..5 off, 6 and 7 later
// - strobes one, two only for backup bucks
// - seal skips strobes two and one down
// - open-drain rails_good follows regulation
// - tight_supervision picks limits and deglitch
// - monitor enabled rails 5 ms after enable
// - release delayed; fault pulls low, powers down
// - rails_good low when off, down, suspend
// - of the load switches only low_volt_switch is sequenced
module pmsq_sequencer #(
  parameter int BASE_CYCLES = pmsq_pkg::BASE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        power_button,
  input  wire logic        line_detect,
  input  wire logic        host_power_request,
  input  wire logic        uvlo,
  input  wire logic        over_temp_shutdown,
  input  wire logic [4:0]  rail_under,
  input  wire logic [4:0]  rail_over,
  output logic      [9:0]  rail_on,
  output logic      [9:0]  rail_discharge,
  output logic             rails_good_out,
  output logic             rails_good_oe_n
);

  // **************************************
  // helpers
  // **************************************
  // rails whose slot field equals strobe k
  function automatic logic [9:0] slot_hits(input logic [39:0] s,
                                           input logic [3:0]  k);
    logic [9:0] h;
    h = '0;
    for (int i = 0; i < pmsq_pkg::RAILS; i++) h[i] = (s[4*i+:4] == k);
    return h;
  endfunction

  // interval after strobe k, in ms (2..5)
  function automatic logic [7:0] step_ms(input logic [17:0] d,
                                         input logic [3:0]  k);
    int idx;
    idx = (k == 4'h0) ? 0 : int'(k) - 1;
    if (idx > 8) idx = 8;
    return 8'(pmsq_pkg::DLY_MIN_MS) + {6'h00, d[2*idx+:2]};
  endfunction

  // slot legalisation: backups own slots 1,2; five_volt_switch, high_volt_switch none
  function automatic logic [3:0] legal_slot(input int r,
                                            input logic [3:0] v);
    logic [3:0] o;
    o = v;
    if (r == pmsq_pkg::FIVESW || r == pmsq_pkg::HIGHSW) o = 4'h0;
    else if (r >= pmsq_pkg::BKA) o = (v <= 4'h2) ? v : 4'h0;
    else if (v == 4'h1 || v == 4'h2 || v > 4'hA) o = 4'h0;
    return o;
  endfunction

  // **************************************
  // pin synchronisers
  // **************************************
  localparam logic [14:0] FILT_RST = 15'h0003;  // button, line idle high
  logic [14:0] sy1, sy2, sy3;  // three-stage chain
  logic [14:0] filt, filt_d;   // agreed level and its last value
  logic [14:0] raw;
  assign raw = {rail_over, rail_under, over_temp_shutdown, uvlo,
                host_power_request, line_detect, power_button};

  // a change counts once stages two and three agree
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sy1    <= FILT_RST;
      sy2    <= FILT_RST;
      sy3    <= FILT_RST;
      filt   <= FILT_RST;
      filt_d <= FILT_RST;
    end else begin
      sy1 <= raw;
      sy2 <= sy1;
      sy3 <= sy2;
      for (int i = 0; i < 15; i++) if (sy2[i] == sy3[i]) filt[i] <= sy2[i];
      filt_d <= filt;
    end
  end

  logic pb, ld, hpr, hard_fault, pb_fall, ld_fall, hpr_rise;
  logic [4:0] under, over;
  assign pb         = filt[0];
  assign ld         = filt[1];
  assign hpr        = filt[2];
  assign hard_fault = filt[3] | filt[4];
  assign under      = filt[9:5];
  assign over       = filt[14:10];
  // line_detect resets high, so a grounded pin after brown-out
  // shows as a falling edge: this is the bias-arrival wake
  assign pb_fall    = filt_d[0] & ~filt[0];
  assign ld_fall    = filt_d[1] & ~filt[1];
  assign hpr_rise   = ~filt_d[2] & filt[2];

  // **************************************
  // time base
  // **************************************
  logic [15:0] base_cnt;  // cycles within one fine tick
  logic [6:0]  ms_div;    // fine ticks within one ms
  logic        tick10, tick_ms;
  assign tick10  = (base_cnt == 16'(BASE_CYCLES - 1));
  assign tick_ms = tick10 && (ms_div == 7'(pmsq_pkg::BASE_PER_MS - 1));

  // one shared prescaler for every delay and deglitch
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      base_cnt <= 16'h0000;
      ms_div   <= 7'h00;
    end else begin
      base_cnt <= tick10 ? 16'h0000 : base_cnt + 16'h0001;
      if (tick_ms) ms_div <= 7'h00;
      else if (tick10) ms_div <= ms_div + 7'h01;
    end
  end

  // **************************************
  // registers
  // **************************************
  logic [4:0]  ctrl;     // mode bits
  logic [39:0] slot;     // strobe_slot, 4 bits per rail
  logic [17:0] dly;      // step_delay
  logic [7:0]  gooddly;  // good_release_delay
  pmsq_pkg::pmsq_state_type st, tgt;
  logic up_run, busy, sw_en_wr, mon_fail;
  assign busy     = up_run || (st == pmsq_pkg::ST_DOWN);
  assign sw_en_wr = reg_wr && (reg_addr == pmsq_pkg::OFS_ENABLE);

  // configuration writes; one field per rail keeps one slot each
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl    <= pmsq_pkg::CTRL_RST;
      slot    <= pmsq_pkg::SLOT_RST;
      dly     <= pmsq_pkg::DELAY_RST;
      gooddly <= pmsq_pkg::GOODDLY_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        pmsq_pkg::OFS_CTRL:    ctrl <= reg_wdata[4:0];
        pmsq_pkg::OFS_SLOT_LO: begin
          for (int i = 0; i < 8; i++)
            slot[4*i+:4] <= legal_slot(i, reg_wdata[4*i+:4]);
        end
        pmsq_pkg::OFS_SLOT_HI: begin
          for (int i = 8; i < 10; i++)
            slot[4*i+:4] <= legal_slot(i, reg_wdata[4*(i-8)+:4]);
        end
        pmsq_pkg::OFS_DELAY:   dly <= reg_wdata[17:0];
        pmsq_pkg::OFS_GOODDLY: gooddly <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) reg_rdata <= 32'h00000000;
    else if (!reg_rd) reg_rdata <= 32'h00000000;
    else begin
      case (reg_addr)
        pmsq_pkg::OFS_CTRL:    reg_rdata <= {27'h0, ctrl};
        pmsq_pkg::OFS_ENABLE:  reg_rdata <= {22'h0, rail_on};
        pmsq_pkg::OFS_SLOT_LO: reg_rdata <= slot[31:0];
        pmsq_pkg::OFS_SLOT_HI: reg_rdata <= {24'h0, slot[39:32]};
        pmsq_pkg::OFS_DELAY:   reg_rdata <= {14'h0, dly};
        pmsq_pkg::OFS_GOODDLY: reg_rdata <= {24'h0, gooddly};
        pmsq_pkg::OFS_STATUS:
          reg_rdata <= {26'h0, mon_fail, rails_good_oe_n, busy, st};
        default:               reg_rdata <= 32'h00000000;
      endcase
    end
  end

  // **************************************
  // wake and power-down decisions
  // **************************************
  logic [3:0]  step;     // current strobe
  logic [7:0]  dcnt;     // ms left in current interval
  logic [8:0]  dn_ms;    // ms since power-down began
  logic [14:0] await_ms; // ms since entering await
  logic [13:0] press_ms; // ms the button has been held
  logic long_press, timeout, dn_go, wake, fire_up, fire_dn;
  pmsq_pkg::pmsq_state_type dn_tgt;

  assign long_press = press_ms >= (ctrl[pmsq_pkg::CTRL_LONG] ?
                      14'(pmsq_pkg::PRESS_LONG_MS) : 14'(pmsq_pkg::PRESS_MS));
  assign timeout = (await_ms >= 15'(pmsq_pkg::AWAIT_MS)) && pb && ld && !hpr;

  // power-down causes and their target state
  always_comb begin
    dn_go  = 1'b0;
    dn_tgt = pmsq_pkg::ST_OFF;
    wake   = 1'b0;
    case (st)
      pmsq_pkg::ST_AWAIT, pmsq_pkg::ST_ACTIVE, pmsq_pkg::ST_SUSPEND: begin
        if (hard_fault || mon_fail) begin
          dn_go  = 1'b1;
          dn_tgt = pmsq_pkg::ST_RECOVERY;
        end else if (long_press) dn_go = 1'b1;
        else if (st == pmsq_pkg::ST_AWAIT && timeout) dn_go = 1'b1;
        else if (st == pmsq_pkg::ST_ACTIVE && !hpr) begin
          dn_go  = 1'b1;
          dn_tgt = ctrl[pmsq_pkg::CTRL_SUSP] ? pmsq_pkg::ST_SUSPEND
                                             : pmsq_pkg::ST_OFF;
        end else if (st == pmsq_pkg::ST_SUSPEND)
          wake = pb_fall || ld_fall || hpr;
      end
      pmsq_pkg::ST_OFF:
        wake = !hard_fault && (pb_fall || ld_fall || hpr_rise);
      pmsq_pkg::ST_RECOVERY: wake = !hard_fault;
      default: ;
    endcase
  end

  assign fire_up = up_run && !dn_go && (dcnt == 8'h00);
  assign fire_dn = (st == pmsq_pkg::ST_DOWN) && (step != 4'h0) &&
                   (dcnt == 8'h00);

  // **************************************
  // state machine, strobes and rail enables
  // **************************************
  logic [9:0] hits;
  logic [7:0] dn_step;
  logic       dn_end;
  assign hits    = slot_hits(slot, step);
  assign dn_step = ctrl[pmsq_pkg::CTRL_STRETCH] ?
                   8'(step_ms(dly, step - 4'h1) * 8'(pmsq_pkg::STRETCH)) :
                   step_ms(dly, step - 4'h1);
  assign dn_end  = tick_ms && (dn_ms == 9'(pmsq_pkg::DOWN_MS - 1));

  // rail enables have one owner; software waits while busy
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st             <= pmsq_pkg::ST_OFF;
      tgt            <= pmsq_pkg::ST_OFF;
      step           <= 4'h0;
      dcnt           <= 8'h00;
      up_run         <= 1'b0;
      rail_on        <= pmsq_pkg::ENABLE_RST;
      rail_discharge <= 10'h000;
    end else begin
      if (dcnt != 8'h00 && tick_ms) dcnt <= dcnt - 8'h01;
      if (dn_go) begin
        st     <= pmsq_pkg::ST_DOWN;
        tgt    <= dn_tgt;
        up_run <= 1'b0;
        step   <= 4'(pmsq_pkg::STROBES);
        dcnt   <= 8'h00;
        if (dn_tgt != pmsq_pkg::ST_SUSPEND) begin
          for (int i = 0; i <= pmsq_pkg::LOWSW; i++)
            if (slot[4*i+:4] == 4'h0) rail_on[i] <= 1'b0;
        end
      end else if (wake) begin
        st     <= pmsq_pkg::ST_AWAIT;
        up_run <= 1'b1;
        step   <= 4'h1;
        dcnt   <= 8'h00;  // first strobe at once
      end else if (fire_up) begin
        rail_on        <= rail_on | hits;
        rail_discharge <= rail_discharge & ~hits;
        if (step == 4'(pmsq_pkg::STROBES)) up_run <= 1'b0;
        else begin
          step <= step + 4'h1;
          dcnt <= step_ms(dly, step);
        end
      end else if (fire_dn) begin
        // sealed backups keep state through strobes two and one
        if (!(ctrl[pmsq_pkg::CTRL_SEAL] && step <= 4'h2)) begin
          rail_on        <= rail_on & ~hits;
          rail_discharge <= rail_discharge | hits;
        end
        step <= step - 4'h1;
        if (step != 4'h1) dcnt <= dn_step;
      end else if (sw_en_wr && !busy) begin
        rail_on        <= reg_wdata[9:0];
        rail_discharge <= rail_discharge & ~reg_wdata[9:0];
      end
      if (st == pmsq_pkg::ST_AWAIT && hpr && !dn_go && !wake)
        st <= pmsq_pkg::ST_ACTIVE;
      if (st == pmsq_pkg::ST_DOWN && dn_end) begin
        st   <= tgt;
        step <= 4'h0;
        if (tgt != pmsq_pkg::ST_SUSPEND) begin
          rail_on[pmsq_pkg::FIVESW] <= 1'b0;
          rail_on[pmsq_pkg::HIGHSW] <= 1'b0;
        end
      end
    end
  end

  // **************************************
  // timers
  // **************************************
  // ms counters, await_ms and press_ms saturating; each clears when its cause is gone
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      dn_ms    <= 9'h000;
      await_ms <= 15'h0000;
      press_ms <= 14'h0000;
    end else begin
      if (st != pmsq_pkg::ST_DOWN) dn_ms <= 9'h000;
      else if (tick_ms) dn_ms <= dn_ms + 9'h001;
      if (st != pmsq_pkg::ST_AWAIT) await_ms <= 15'h0000;
      else if (tick_ms && await_ms < 15'(pmsq_pkg::AWAIT_MS))
        await_ms <= await_ms + 15'h0001;
      if (pb) press_ms <= 14'h0000;
      else if (tick_ms && press_ms < 14'(pmsq_pkg::PRESS_LONG_MS))
        press_ms <= press_ms + 14'h0001;
    end
  end

  // **************************************
  // supervisor
  // **************************************
  logic [2:0] arm_ms [5];  // ms since rail enabled
  logic [6:0] uv_cnt [5];  // fine ticks below window
  logic [6:0] ov_cnt [5];  // fine ticks above window
  logic [4:0] armed, uv_bad, ov_bad;
  logic [6:0] uv_lim;
  logic       tight;
  assign tight  = ctrl[pmsq_pkg::CTRL_TIGHT];
  assign uv_lim = tight ? 7'(pmsq_pkg::UV_TIGHT_TK)
                        : 7'(pmsq_pkg::UV_RELAX_TK);
  always_comb begin
    for (int i = 0; i < pmsq_pkg::MON; i++) begin
      armed[i]  = rail_on[i] && (arm_ms[i] == 3'(pmsq_pkg::ARM_MS));
      uv_bad[i] = uv_cnt[i] >= uv_lim;
      ov_bad[i] = tight && (ov_cnt[i] >= 7'(pmsq_pkg::OV_TK));
    end
  end
  assign mon_fail = |(armed & (uv_bad | ov_bad));

  // a rail back in window clears at once: rising deglitch is
  // shorter than one fine tick, so it is not counted separately
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < pmsq_pkg::MON; i++) begin
        arm_ms[i] <= 3'h0;
        uv_cnt[i] <= 7'h00;
        ov_cnt[i] <= 7'h00;
      end
    end else begin
      for (int i = 0; i < pmsq_pkg::MON; i++) begin
        if (!rail_on[i]) arm_ms[i] <= 3'h0;
        else if (tick_ms && !armed[i]) arm_ms[i] <= arm_ms[i] + 3'h1;
        if (!armed[i] || !under[i]) uv_cnt[i] <= 7'h00;
        else if (tick10 && !uv_bad[i]) uv_cnt[i] <= uv_cnt[i] + 7'h01;
        if (!armed[i] || !over[i]) ov_cnt[i] <= 7'h00;
        else if (tick10 && ov_cnt[i] < 7'(pmsq_pkg::OV_TK))
          ov_cnt[i] <= ov_cnt[i] + 7'h01;
      end
    end
  end

  // **************************************
  // rails_good open-drain output
  // **************************************
  logic [7:0] good_ms;  // ms since power-up strobes finished
  logic       on_run, release_ok;
  assign on_run = (st == pmsq_pkg::ST_AWAIT || st == pmsq_pkg::ST_ACTIVE);
  assign release_ok = on_run && !up_run && !dn_go && !mon_fail &&
                      (good_ms >= gooddly) && (|rail_on[4:0]) &&
                      ((armed | ~rail_on[4:0]) == 5'h1F);

  // drive low unless released; oe_n low means pulling the pin
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      good_ms         <= 8'h00;
      rails_good_out  <= 1'b0;
      rails_good_oe_n <= 1'b0;  // low after power-up
    end else begin
      if (!on_run || up_run) good_ms <= 8'h00;
      else if (tick_ms && good_ms < gooddly) good_ms <= good_ms + 8'h01;
      rails_good_out  <= 1'b0;
      rails_good_oe_n <= release_ok;
    end
  end

  // **************************************
  // checks
  // **************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_DOWN_LEN: assert property (
    ($past(st) == pmsq_pkg::ST_DOWN && st != pmsq_pkg::ST_DOWN)
    |-> $past(dn_ms) == 9'(pmsq_pkg::DOWN_MS - 1))
    else $error("power-down did not last 500 ms");
  AST_UP_SPACING: assert property (
    fire_up && step != 4'hA |=> !fire_up [*8])
    else $error("power-up strobes too close");
  AST_SEAL_KEEP: assert property (
    fire_dn && ctrl[pmsq_pkg::CTRL_SEAL] && step < 4'h3
    |=> $stable(rail_on[9:8]))
    else $error("sealed backup rail changed");
  AST_SW_IGNORED: assert property (
    sw_en_wr && busy && !fire_up && !fire_dn && !dn_go && !dn_end
    |=> $stable(rail_on))
    else $error("enable write taken while busy");
  AST_SLOT0_KEPT: assert property (
    fire_up |=> ((rail_on ^ $past(rail_on)) & ~$past(hits)) == 10'h000)
    else $error("strobe touched another rail");
  AST_SUSP_LOW: assert property (
    (st == pmsq_pkg::ST_SUSPEND) [*2] |-> !rails_good_oe_n)
    else $error("rails_good released in suspend");
  AST_TO_ACTIVE: assert property (
    st == pmsq_pkg::ST_AWAIT && hpr && !dn_go
    |=> st == pmsq_pkg::ST_ACTIVE)
    else $error("host request did not reach active");
  AST_LOADSW: assert property (
    !$stable(rail_on[7:6])
    |-> $past(sw_en_wr) || $past(st) == pmsq_pkg::ST_DOWN)
    else $error("load switch moved by sequencer");
  AST_WAKE_BLOCK: assert property (
    st == pmsq_pkg::ST_OFF && hard_fault |=> st == pmsq_pkg::ST_OFF)
    else $error("woke during lockout");
  AST_FAULT_DOWN: assert property (
    mon_fail && st == pmsq_pkg::ST_ACTIVE
    |=> !rails_good_oe_n && st == pmsq_pkg::ST_DOWN)
    else $error("rail fault not handled");

  CVR_WAKE: cover property (
    st == pmsq_pkg::ST_OFF ##1 st == pmsq_pkg::ST_AWAIT);
  CVR_SUSP: cover property (
    st == pmsq_pkg::ST_DOWN ##1 st == pmsq_pkg::ST_SUSPEND);
  CVR_RECOV: cover property (
    st == pmsq_pkg::ST_DOWN ##1 st == pmsq_pkg::ST_RECOVERY);

endmodule

// file: dv/pmsq_host_model.sv
// host and push-button model facing the power sequencer
// assumes the bench commands it through plain level inputs
`timescale 1ns/1ps
// ******************************
// far-side pins
// ******************************
module pmsq_host_model (
  input  wire logic       press,
  input  wire logic       request,
  input  wire logic       fault,
  output logic            power_button,
  output logic            line_detect,
  output logic            host_power_request,
  output logic      [4:0] rail_under,
  output logic      [4:0] rail_over
);
  // button pulls low when pressed; idle high
  assign power_button       = ~press;
  // pull-up only, so the detect pin never wakes here
  assign line_detect        = 1'b1;
  assign host_power_request = request;
  // fault sags rail 1 only, so the others stay a clean reference
  assign rail_under         = fault ? 5'h02 : 5'h00;
  assign rail_over          = 5'h00;
endmodule

// file: dv/pmsq_sequencer_tb.sv
// self-checking bench of the power sequencer
// assumes a 25 MHz clock and a shortened time base
`timescale 1ns/1ps
// ******************************
// bench
// ******************************
module pmsq_sequencer_tb;
  localparam int MS = pmsq_pkg::BASE_PER_MS;  // one cycle per fine tick
  logic        mclk, resetn, reg_wr, reg_rd, press, request, fault, lock;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic        power_button, line_detect, host_power_request;
  logic [4:0]  rail_under, rail_over;
  logic [9:0]  rail_on, rail_discharge;
  logic        rails_good_out, rails_good_oe_n;
  int          errors, comparisons;
  realtime     t0;
  pmsq_sequencer #(.BASE_CYCLES(1)) dut_u (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_button(power_button),
    .line_detect(line_detect), .host_power_request(host_power_request),
    .uvlo(lock), .over_temp_shutdown(1'b0), .rail_under(rail_under),
    .rail_over(rail_over), .rail_on(rail_on),
    .rail_discharge(rail_discharge), .rails_good_out(rails_good_out),
    .rails_good_oe_n(rails_good_oe_n));
  pmsq_host_model host_u (.press(press), .request(request), .fault(fault),
    .power_button(power_button), .line_detect(line_detect),
    .host_power_request(host_power_request), .rail_under(rail_under),
    .rail_over(rail_over));
  // free-running 40 ns clock
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  // data stands only after the taking edge, so sample just past it
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // elapsed ms since t0 must fall inside the window
  task automatic chk_ms(input real lo, input real hi);
    real tm;
    tm = ($realtime - t0) / (MS * 40.0);
    comparisons++;
    if (tm < lo || tm > hi) begin
      errors++;
      $display("BAD %0t took %0f ms", $time, tm);
    end
  endtask
  // polls a register; a bound that runs out ends the run
  task automatic wait_reg(input logic [7:0] a, input logic [31:0] m,
                          input logic [31:0] v, input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(a, d);
      if ((d & m) === v) return;
    end
    errors++;
    $display("BAD %0t wait expired", $time);
    results();
  endtask
  task automatic results();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, press, request, fault, lock} = 6'h00;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    errors = 0;
    comparisons = 0;
    resetn = 1'b0;
    repeat (16) @(posedge mclk);
    resetn <= 1'b1;
    chk({31'h0, rails_good_oe_n}, 32'h0);
    rd(pmsq_pkg::OFS_GOODDLY, d);
    chk(d, 32'h0000000A);
    rd(pmsq_pkg::OFS_SLOT_LO, d);
    chk(d, 32'h00876543);
    rd(8'h1C, d);
    chk(d, 32'h00000000);
    // lockout held while the button falls: no wake may follow
    {lock, press} <= 2'b11;
    repeat (8) rd(pmsq_pkg::OFS_STATUS, d);
    chk(d & 32'hF, 32'h0);
    {lock, press} <= 2'b00;
    repeat (8) @(posedge mclk);
    press <= 1'b1;
    wait_reg(pmsq_pkg::OFS_ENABLE, 32'h100, 32'h100, 50);
    t0 = $realtime;
    chk(d, 32'h00000100);
    wr(pmsq_pkg::OFS_ENABLE, 32'h0C0);
    rd(pmsq_pkg::OFS_STATUS, d);
    chk(d & 32'hF, 32'h9);
    wait_reg(pmsq_pkg::OFS_STATUS, 32'h8, 32'h0, 3000);
    chk_ms(17.0, 19.5);
    t0 = $realtime;
    rd(pmsq_pkg::OFS_ENABLE, d);
    chk(d, 32'h0000033F);
    press <= 1'b0;
    request <= 1'b1;
    wait_reg(pmsq_pkg::OFS_STATUS, 32'h7, 32'h2, 50);
    wait_reg(pmsq_pkg::OFS_STATUS, 32'h10, 32'h10, 6000);
    chk_ms(9.0, 16.0);
    chk({31'h0, rails_good_oe_n}, 32'h1);
    wr(pmsq_pkg::OFS_ENABLE, 32'h37E);
    rd(pmsq_pkg::OFS_ENABLE, d);
    chk(d, 32'h0000037E);
    chk({31'h0, rails_good_oe_n}, 32'h1);
    wr(pmsq_pkg::OFS_CTRL, 32'h00000002);  // seal the backup rails
    fault <= 1'b1;
    wait_reg(pmsq_pkg::OFS_STATUS, 32'h7, 32'h5, 500);
    t0 = $realtime;
    chk({31'h0, rails_good_oe_n}, 32'h0);
    wait_reg(pmsq_pkg::OFS_ENABLE, 32'h20, 32'h0, 2000);
    chk_ms(3.0, 5.5);
    chk({22'h0, rail_on & 10'h070}, 32'h50);
    chk({31'h0, rail_discharge[5]}, 32'h1);
    // recovery lasts one cycle once lockout is clear, then the
    // sequencer rewakes: poll for the fresh power-up instead
    wait_reg(pmsq_pkg::OFS_STATUS, 32'hF, 32'h9, 26000);
    chk_ms(498.0, 501.5);
    chk({22'h0, rail_on & 10'h0FF}, 32'h0);
    chk({30'h0, rail_on[9:8]}, 32'h3);
    results();
  end
endmodule
